/* File: rsc_far_side.sv */
// Far side model: supply rails, their comparators and the external reset pin
`timescale 1ns/1ns

module rsc_far_side
    import rsc_pkg::*;
#(
    parameter int PREC_MV = 1000
) (
    input  wire logic [MV_W-1:0] analog_mv_i,
    input  wire logic [MV_W-1:0] digital_mv_i,
    input  wire logic [MV_W-1:0] analog_low_trip_mv_i,
    input  wire logic [MV_W-1:0] digital_low_trip_mv_i,
    input  wire logic [MV_W-1:0] analog_high_trip_mv_i,
    input  wire logic            pin_pull_low_i,
    output logic                 precise_analog_trip_o,
    output logic                 precise_digital_trip_o,
    output logic                 analog_low_cmp_o,
    output logic                 digital_low_cmp_o,
    output logic                 analog_high_cmp_o,
    output logic                 external_reset_n_o
);
    // Regulator outputs against the precise reference
    assign precise_analog_trip_o  = (analog_mv_i < 13'(PREC_MV));
    assign precise_digital_trip_o = (digital_mv_i < 13'(PREC_MV));
    // Window comparators against the selected low and fixed high trip levels
    assign analog_low_cmp_o  = (analog_mv_i < analog_low_trip_mv_i);
    assign digital_low_cmp_o = (digital_mv_i < digital_low_trip_mv_i);
    assign analog_high_cmp_o = (analog_mv_i > analog_high_trip_mv_i);
    // Internal pull-up: a released pin reads high
    assign external_reset_n_o = pin_pull_low_i ? 1'b0 : 1'b1;
endmodule : rsc_far_side

/* File: rsc_pkg.sv */
// Package with constants and types of the reset source controller
package rsc_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int INITIAL_POWER_ON_MONITOR_MIN_NS   = 150;
    localparam int INITIAL_POWER_ON_MONITOR_MIN_CYC  = (INITIAL_POWER_ON_MONITOR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Reset stretch counter
    localparam int             RST_CNT_W    = 5;
    localparam logic [4:0]     INITIAL_POWER_ON_MONITOR_MIN_CNT = 5'(INITIAL_POWER_ON_MONITOR_MIN_CYC);

    // Supply monitor trip levels in millivolts
    localparam int             LV_TRIP_BASE_MV = 1700;
    localparam int             LV_TRIP_STEP_MV = 250;
    localparam int             LV_TRIP_CODE_W  = 4;
    localparam int             MV_W            = 13;
    localparam logic [12:0]    AHV_TRIP_MV     = 13'(5750);

    // Counter widths
    localparam int             BUZZ_CNT_W = 16;
    localparam int             BUZZ_ON_W  = 4;
    localparam int             WDT_CNT_W  = 16;

    // Synchroniser lanes: 0 ext reset pin, 1/2 precise trips, 3..5 window comparators
    localparam int             SYNC_N       = 6;
    localparam int             SYNC_EXT     = 0;
    localparam int             SYNC_PRE_DIG = 1;
    localparam int             SYNC_PRE_ANA = 2;
    localparam int             SYNC_ALV     = 3;
    localparam int             SYNC_DLV     = 4;
    localparam int             SYNC_AHV     = 5;
    localparam logic [5:0]     SYNC_RST     = 6'h01;

    // Monitor interrupt lanes
    localparam int             IRQ_N = 3;

    // Sticky reset cause and monitor event record
    typedef struct packed {
        logic precise;
        logic external;
        logic software;
        logic watchdog;
        logic analog_low;
        logic digital_low;
        logic analog_high;
    } rsc_status_t;

    localparam int             STATUS_W = 7;

    // Complete controller state
    typedef struct packed {
        logic [SYNC_N-1:0]          sync1;
        logic [SYNC_N-1:0]          sync2;
        logic [SYNC_N-1:0]          sync3;
        logic [SYNC_N-1:0]          filt;
        logic [RST_CNT_W-1:0]       rst_cnt;
        logic                       sys_rst;
        logic                       por_seen;
        logic                       boot_done;
        logic [BUZZ_CNT_W-1:0]      buzz_cnt;
        logic [BUZZ_ON_W-1:0]       buzz_left;
        logic                       wdt_en;
        logic [WDT_CNT_W-1:0]       wdt_cnt;
        rsc_status_t                status;
        logic [IRQ_N-1:0]           irq_pend;
        logic [IRQ_N-1:0]           irq_out;
        logic                       wake;
        logic                       mon_act;
        logic                       prec_en_dig;
        logic                       prec_en_ana;
        logic [MV_W-1:0]            alv_mv;
        logic [MV_W-1:0]            dlv_mv;
    } rsc_state_t;

endpackage : rsc_pkg

/* File: rsc_reset_source_controller.sv */
// Reset source controller: merges reset causes into one system reset
`timescale 1ns/1ns

module rsc_reset_source_controller
    import rsc_pkg::*;
#(
    parameter int BUZZ_ON_CYC = 4
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       external_reset_n_i,
    input  wire logic                       precise_digital_trip_i,
    input  wire logic                       precise_analog_trip_i,
    input  wire logic                       analog_regulator_en_i,
    input  wire logic                       analog_low_cmp_i,
    input  wire logic                       digital_low_cmp_i,
    input  wire logic                       analog_high_cmp_i,
    input  wire logic [LV_TRIP_CODE_W-1:0]  analog_low_trip_sel_i,
    input  wire logic [LV_TRIP_CODE_W-1:0]  digital_low_trip_sel_i,
    input  wire logic                       analog_low_reset_sel_i,
    input  wire logic                       digital_low_reset_sel_i,
    input  wire logic [IRQ_N-1:0]           monitor_irq_en_i,
    input  wire logic [IRQ_N-1:0]           monitor_irq_clear_i,
    input  wire logic                       sleep_i,
    input  wire logic                       hibernate_i,
    input  wire logic [BUZZ_CNT_W-1:0]      buzz_period_i,
    input  wire logic                       boot_done_i,
    input  wire logic                       software_reset_request_i,
    input  wire logic                       software_reset_disable_i,
    input  wire logic                       watchdog_enable_set_i,
    input  wire logic                       watchdog_kick_i,
    input  wire logic [WDT_CNT_W-1:0]       watchdog_timeout_i,
    input  wire logic [STATUS_W-1:0]        status_clear_i,
    output logic                            system_reset_o,
    output rsc_status_t                     status_o,
    output logic [IRQ_N-1:0]                monitor_irq_o,
    output logic                            wakeup_o,
    output logic                            monitors_active_o,
    output logic                            initial_power_on_monitor_en_o,
    output logic                            precise_digital_en_o,
    output logic                            precise_analog_en_o,
    output logic                            watchdog_enabled_o,
    output logic [MV_W-1:0]                 analog_low_trip_mv_o,
    output logic [MV_W-1:0]                 digital_low_trip_mv_o,
    output logic [MV_W-1:0]                 analog_high_trip_mv_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    if (BUZZ_ON_CYC < 1 || BUZZ_ON_CYC > 15) begin : g_chk_buzz
        $error("BUZZ_ON_CYC must lie in 1..15");
    end

    localparam logic [BUZZ_ON_W-1:0] BUZZ_ON_CNT = BUZZ_ON_W'(BUZZ_ON_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // State and decoded events

    rsc_state_t        q;
    rsc_state_t        d;
    logic              low_power;
    logic              buzzing;
    logic              prec_trip;
    logic              alv_hit;
    logic              dlv_hit;
    logic              ahv_hit;
    logic              alv_rst;
    logic              dlv_rst;
    logic              ext_rst;
    logic              sw_fire;
    logic              wdt_fire;
    logic              any_src;
    logic [IRQ_N-1:0]  irq_ev;
    logic [SYNC_N-1:0] agree;
    rsc_status_t       status_set;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        d = q;

        // Three-stage synchronisers, value taken when stages two and three agree
        d.sync1 = {analog_high_cmp_i, digital_low_cmp_i, analog_low_cmp_i,
                   precise_analog_trip_i, precise_digital_trip_i, external_reset_n_i};
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        agree   = q.sync2 ~^ q.sync3;
        d.filt  = (agree & q.sync3) | (~agree & q.filt);

        // Power mode and periodic buzz window in sleep
        low_power = sleep_i | hibernate_i;
        buzzing   = (q.buzz_left != '0);
        if (sleep_i && !hibernate_i) begin
            if (q.buzz_cnt >= buzz_period_i) begin
                d.buzz_cnt  = '0;
                d.buzz_left = BUZZ_ON_CNT;
            end else begin
                d.buzz_cnt  = q.buzz_cnt + 16'h0001;
                d.buzz_left = buzzing ? q.buzz_left - 4'h1 : 4'h0;
            end
        end else begin
            d.buzz_cnt  = '0;
            d.buzz_left = '0;
        end

        // Boot hand-over from initial to precise monitor
        if (boot_done_i && !q.sys_rst) begin
            d.boot_done = 1'h1;
        end
        if (!q.sys_rst) begin
            d.por_seen = 1'h1;
        end

        // Monitor enables: off until power-on done, buzzed in sleep
        d.mon_act     = q.por_seen && (!low_power || (sleep_i && !hibernate_i && buzzing));
        d.prec_en_dig = q.boot_done && (!low_power || (sleep_i && !hibernate_i && buzzing));
        d.prec_en_ana = d.prec_en_dig && analog_regulator_en_i;

        // Trip level readback
        d.alv_mv = MV_W'(LV_TRIP_BASE_MV + LV_TRIP_STEP_MV * int'(analog_low_trip_sel_i));
        d.dlv_mv = MV_W'(LV_TRIP_BASE_MV + LV_TRIP_STEP_MV * int'(digital_low_trip_sel_i));

        // Supply monitor events
        prec_trip = (q.prec_en_dig && q.filt[SYNC_PRE_DIG])
                  || (q.prec_en_ana && q.filt[SYNC_PRE_ANA]);
        alv_hit   = q.mon_act && q.filt[SYNC_ALV];
        dlv_hit   = q.mon_act && q.filt[SYNC_DLV];
        ahv_hit   = q.mon_act && q.filt[SYNC_AHV];
        alv_rst   = alv_hit && analog_low_reset_sel_i;
        dlv_rst   = dlv_hit && digital_low_reset_sel_i;
        irq_ev[0] = alv_hit && !analog_low_reset_sel_i && monitor_irq_en_i[0];
        irq_ev[1] = dlv_hit && !digital_low_reset_sel_i && monitor_irq_en_i[1];
        irq_ev[2] = ahv_hit && monitor_irq_en_i[2];

        // Pin and software sources, pin live in every power mode
        ext_rst = !q.filt[SYNC_EXT];
        sw_fire = software_reset_request_i && !software_reset_disable_i;

        // Watchdog: enable sticky until power-on, counter cleared by kick or reset
        if (watchdog_enable_set_i) begin
            d.wdt_en = 1'h1;
        end
        wdt_fire = q.wdt_en && !q.sys_rst && (q.wdt_cnt >= watchdog_timeout_i);
        if (q.sys_rst || watchdog_kick_i || !q.wdt_en || wdt_fire) begin
            d.wdt_cnt = '0;
        end else begin
            d.wdt_cnt = q.wdt_cnt + 16'h0001;
        end

        // Merge sources, stretch, release on the clock
        any_src   = prec_trip || alv_rst || dlv_rst || ext_rst || sw_fire || wdt_fire;
        d.sys_rst = any_src || (q.rst_cnt != '0);
        if (any_src) begin
            d.rst_cnt = INITIAL_POWER_ON_MONITOR_MIN_CNT;
        end else if (q.rst_cnt != '0) begin
            d.rst_cnt = q.rst_cnt - 5'h01;
        end else begin
            d.rst_cnt = '0;
        end

        // Sticky status, a new event beats a clear in the same cycle
        status_set.precise     = prec_trip;
        status_set.external    = ext_rst;
        status_set.software    = sw_fire;
        status_set.watchdog    = wdt_fire;
        status_set.analog_low  = alv_hit;
        status_set.digital_low = dlv_hit;
        status_set.analog_high = ahv_hit;
        d.status = (q.status & ~status_clear_i) | status_set;

        // Interrupts held pending, shown only once the device is active again
        d.irq_pend = (q.irq_pend & ~monitor_irq_clear_i) | irq_ev;
        d.irq_out  = low_power ? '0 : q.irq_pend;

        // Wakeup request on pending interrupt or any reset source
        d.wake = low_power && ((|q.irq_pend) || any_src);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register, power-on clears watchdog enable and most state, loads synchronisers, stretch count, reset and trip levels

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q         <= '0;
            q.sync1   <= SYNC_RST;
            q.sync2   <= SYNC_RST;
            q.sync3   <= SYNC_RST;
            q.filt    <= SYNC_RST;
            q.rst_cnt <= INITIAL_POWER_ON_MONITOR_MIN_CNT;
            q.sys_rst <= 1'h1;
            q.alv_mv  <= 13'(LV_TRIP_BASE_MV);
            q.dlv_mv  <= 13'(LV_TRIP_BASE_MV);
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops

    assign system_reset_o                = q.sys_rst;
    assign status_o                      = q.status;
    assign monitor_irq_o                 = q.irq_out;
    assign wakeup_o                      = q.wake;
    assign monitors_active_o             = q.mon_act;
    assign precise_digital_en_o          = q.prec_en_dig;
    assign precise_analog_en_o           = q.prec_en_ana;
    assign watchdog_enabled_o            = q.wdt_en;
    assign analog_low_trip_mv_o          = q.alv_mv;
    assign digital_low_trip_mv_o         = q.dlv_mv;

    // Fixed high trip level and the initial monitor enable still come from a flop
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            analog_high_trip_mv_o         <= AHV_TRIP_MV;
            initial_power_on_monitor_en_o <= 1'h1;
        end else begin
            analog_high_trip_mv_o         <= AHV_TRIP_MV;
            initial_power_on_monitor_en_o <= !q.boot_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    localparam int MIN_HI = INITIAL_POWER_ON_MONITOR_MIN_CYC;

    logic [RST_CNT_W:0] hi_cnt_q;

    // Length of current reset pulse, saturating
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hi_cnt_q <= '0;
        end else if (!q.sys_rst) begin
            hi_cnt_q <= '0;
        end else if (hi_cnt_q != '1) begin
            hi_cnt_q <= hi_cnt_q + 6'h01;
        end
    end

    // Checks run on the system clock, off during power-on
    default clocking cb_main @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Pulse length, holding, stickiness, low-power gating, wakeup and reset sources
    AST_MIN_PULSE: assert property ($fell(q.sys_rst) |-> $past(hi_cnt_q) >= MIN_HI)
        else $error("reset pulse shorter than minimum");
    AST_EXT_HOLDS: assert property (!q.filt[SYNC_EXT] |=> q.sys_rst [*8])
        else $error("external reset did not hold system reset");
    AST_SW_BLOCKED: assert property ($rose(q.status.software)
                                     |-> $past(software_reset_request_i && !software_reset_disable_i))
        else $error("software reset fired while blocked");
    AST_WDT_STICKY: assert property (q.wdt_en |=> q.wdt_en)
        else $error("watchdog enable cleared without power-on");
    AST_IRQ_AFTER_WAKE: assert property ($past(sleep_i || hibernate_i) |-> q.irq_out == '0)
        else $error("interrupt shown before wakeup completed");
    AST_PREC_OFF_HIB: assert property (hibernate_i |=> !q.prec_en_dig && !q.prec_en_ana)
        else $error("precise monitor active in hibernate");
    AST_MON_AFTER_POR: assert property (!q.por_seen |=> !q.mon_act)
        else $error("monitors active before power-on completed");
    AST_LV_RESET: assert property (q.mon_act && q.filt[SYNC_DLV] && digital_low_reset_sel_i
                                   |=> q.sys_rst ##1 q.sys_rst)
        else $error("low-voltage reset not raised");
    AST_STATUS_KEEP: assert property (q.status.external && !status_clear_i[5] |=> q.status.external)
        else $error("status bit lost without clear");
    AST_WAKE: assert property ((sleep_i || hibernate_i) && !q.filt[SYNC_EXT] |=> q.wake)
        else $error("no wakeup on reset source in low power");
    AST_WDT_FIRE: assert property (q.wdt_en && !q.sys_rst && q.wdt_cnt >= watchdog_timeout_i
                                   |=> q.sys_rst && q.status.watchdog)
        else $error("watchdog timeout did not reset");

    // Reset sources and pulse stretch
    AST_SW_FIRES: assert property (software_reset_request_i && !software_reset_disable_i |=> q.sys_rst)
        else $error("software reset not taken");
    AST_RST_HOLD: assert property (q.rst_cnt != '0 |=> q.sys_rst)
        else $error("reset released during stretch");
    AST_EXT_STATUS: assert property (!q.filt[SYNC_EXT] |=> q.status.external)
        else $error("external reset not recorded");
    AST_PREC_TRIP: assert property (q.prec_en_dig && q.filt[SYNC_PRE_DIG]
                                    |=> q.sys_rst && q.status.precise)
        else $error("precise trip did not reset");
    AST_ALV_RESET: assert property (q.mon_act && q.filt[SYNC_ALV] && analog_low_reset_sel_i
                                    |=> q.sys_rst)
        else $error("analog low-voltage reset not raised");

    // Precise monitor and boot hand-over
    AST_PREC_ANA_OFF: assert property (!analog_regulator_en_i |=> !q.prec_en_ana)
        else $error("analog precise part on with regulator off");
    AST_INITIAL_POWER_ON_MONITOR_OFF: assert property (q.boot_done |=> !initial_power_on_monitor_en_o)
        else $error("initial monitor on after boot");
    AST_PREC_DIG_ON: assert property (q.boot_done && !sleep_i && !hibernate_i |=> q.prec_en_dig)
        else $error("digital precise part off");

    // Supply monitors in sleep and hibernate
    AST_BUZZ_ONLY: assert property (sleep_i && q.buzz_left == '0 |=> !q.mon_act)
        else $error("monitors active outside buzz window");
    AST_HIB_MON_OFF: assert property (hibernate_i |=> !q.mon_act)
        else $error("monitors active in hibernate");
    AST_AHV_IRQ: assert property (q.mon_act && q.filt[SYNC_AHV] && monitor_irq_en_i[2] |=> q.irq_pend[2])
        else $error("high-voltage interrupt not pending");
    AST_WAKE_IRQ: assert property ((sleep_i || hibernate_i) && |q.irq_pend |=> q.wake)
        else $error("no wakeup on pending interrupt");

    // Watchdog counter
    AST_WDT_HELD: assert property (q.sys_rst |=> q.wdt_cnt == '0)
        else $error("watchdog counted during reset");

    COV_WDT: cover property ($rose(q.status.watchdog));
    COV_SW: cover property ($rose(q.status.software) ##[1:40] $fell(q.sys_rst));
    COV_SLEEP_IRQ: cover property (sleep_i && |q.irq_pend ##1 q.wake ##[1:100] |q.irq_out);
    COV_LV_RST: cover property ($rose(q.status.analog_low) && analog_low_reset_sel_i);
    COV_EXT_HIB: cover property (hibernate_i && !q.filt[SYNC_EXT] ##1 q.wake);

endmodule : rsc_reset_source_controller

/* File: tb_top.sv */
// Self-checking testbench for the reset source controller
`timescale 1ns/1ns

module tb_top;
    import rsc_pkg::*;
    logic              clk_i, rst_i, ext_low, reg_en, arst, drst, slp, hib, boot, swr, swd, wds, wdk;
    logic              ext_n, pat, pdt, alc, dlc, ahc, sys_rst, wake, mact, initial_power_on_monitor_en, pden, paen, wden;
    logic [MV_W-1:0]   a_mv, d_mv, alv_mv, dlv_mv, ahv_mv;
    logic [3:0]        asel, dsel;
    logic [2:0]        irq_en, irq_clr, irq;
    logic [15:0]       bper, wto;
    logic [6:0]        sclr;
    rsc_status_t       status;
    int                num_errors = 0;
    int                n_checks = 0;

    rsc_far_side u_far (.analog_mv_i(a_mv), .digital_mv_i(d_mv), .analog_low_trip_mv_i(alv_mv),
        .digital_low_trip_mv_i(dlv_mv), .analog_high_trip_mv_i(ahv_mv), .pin_pull_low_i(ext_low),
        .precise_analog_trip_o(pat), .precise_digital_trip_o(pdt), .analog_low_cmp_o(alc),
        .digital_low_cmp_o(dlc), .analog_high_cmp_o(ahc), .external_reset_n_o(ext_n));

    rsc_reset_source_controller #(.BUZZ_ON_CYC(8)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .external_reset_n_i(ext_n), .precise_digital_trip_i(pdt), .precise_analog_trip_i(pat),
        .analog_regulator_en_i(reg_en), .analog_low_cmp_i(alc), .digital_low_cmp_i(dlc),
        .analog_high_cmp_i(ahc), .analog_low_trip_sel_i(asel), .digital_low_trip_sel_i(dsel),
        .analog_low_reset_sel_i(arst), .digital_low_reset_sel_i(drst), .monitor_irq_en_i(irq_en),
        .monitor_irq_clear_i(irq_clr), .sleep_i(slp), .hibernate_i(hib), .buzz_period_i(bper),
        .boot_done_i(boot), .software_reset_request_i(swr), .software_reset_disable_i(swd),
        .watchdog_enable_set_i(wds), .watchdog_kick_i(wdk), .watchdog_timeout_i(wto),
        .status_clear_i(sclr), .system_reset_o(sys_rst), .status_o(status), .monitor_irq_o(irq),
        .wakeup_o(wake), .monitors_active_o(mact), .initial_power_on_monitor_en_o(initial_power_on_monitor_en),
        .precise_digital_en_o(pden), .precise_analog_en_o(paen), .watchdog_enabled_o(wden),
        .analog_low_trip_mv_o(alv_mv), .digital_low_trip_mv_o(dlv_mv), .analog_high_trip_mv_o(ahv_mv));

    // Free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, comparison and wait helpers
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    function automatic logic sig(input int s);
        case (s)
            0: return sys_rst;
            1: return mact;
            2: return wake;
            3: return irq[0];
            default: return irq[2];
        endcase
    endfunction : sig

    // Bounded wait; running out counts a mismatch and ends the run
    task automatic wait_for(input int s, input logic lvl, input int max);
        int n;
        n = 0;
        #1;
        while (sig(s) !== lvl && n < max) begin
            tick(1);
            n++;
        end
        chk(16'(sig(s)), 16'(lvl));
        if (sig(s) !== lvl) begin
            test_done();
        end
    endtask : wait_for

    // Lets monitor events settle, then clears status and interrupts
    task automatic clear_all();
        tick(8);
        @(posedge clk_i);
        sclr    <= 7'h7F;
        irq_clr <= 3'h7;
        @(posedge clk_i);
        sclr    <= 7'h00;
        irq_clr <= 3'h0;
        tick(2);
        chk(16'(status), 16'h0000);
        chk(16'(irq), 16'h0000);
    endtask : clear_all

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int n;
        rst_i = 1'b1; ext_low = 1'b0; reg_en = 1'b1; arst = 1'b0; drst = 1'b0; slp = 1'b0;
        hib = 1'b0; boot = 1'b0; swr = 1'b0; swd = 1'b0; wds = 1'b0; wdk = 1'b0;
        a_mv = 13'h0CE4; d_mv = 13'h0CE4; asel = 4'h0; dsel = 4'h0; irq_en = 3'h7;
        irq_clr = 3'h0; bper = 16'h0014; wto = 16'h0032; sclr = 7'h00;
        tick(19);
        chk(16'(sys_rst), 16'h0001);
        chk(16'(status), 16'h0000);
        chk(16'(wden), 16'h0000);
        chk(16'(initial_power_on_monitor_en), 16'h0001);
        chk(16'(ahv_mv), 16'h1676);
        @(posedge clk_i);
        rst_i <= 1'b0;
        n = 0;
        while (sys_rst !== 1'b0 && n < 40) begin
            tick(1);
            n++;
        end
        chk(16'(n >= INITIAL_POWER_ON_MONITOR_MIN_CYC), 16'h0001);
        // Boot hand-over and analog regulator off
        @(posedge clk_i);
        boot <= 1'b1;
        @(posedge clk_i);
        boot   <= 1'b0;
        reg_en <= 1'b0;
        tick(3);
        chk(16'(initial_power_on_monitor_en), 16'h0000);
        chk(16'(pden), 16'h0001);
        chk(16'(paen), 16'h0000);
        @(posedge clk_i);
        reg_en <= 1'b1;
        tick(3);
        chk(16'(paen), 16'h0001);
        // Every trip code on both low monitors
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_i);
            asel <= 4'(i);
            dsel <= 4'(15 - i);
            tick(2);
            chk(16'(alv_mv), 16'(LV_TRIP_BASE_MV + LV_TRIP_STEP_MV * i));
            chk(16'(dlv_mv), 16'(LV_TRIP_BASE_MV + LV_TRIP_STEP_MV * (15 - i)));
        end
        @(posedge clk_i);
        asel <= 4'h0;
        dsel <= 4'h0;
        // Software reset blocked, then taken
        swd <= 1'b1;
        swr <= 1'b1;
        @(posedge clk_i);
        swr <= 1'b0;
        tick(20);
        chk(16'(sys_rst), 16'h0000);
        @(posedge clk_i);
        swd <= 1'b0;
        swr <= 1'b1;
        @(posedge clk_i);
        swr <= 1'b0;
        wait_for(0, 1'b1, 3);
        wait_for(0, 1'b0, 30);
        chk(16'(status.software), 16'h0001);
        clear_all();
        // External pin held low while hibernating
        @(posedge clk_i);
        hib     <= 1'b1;
        ext_low <= 1'b1;
        wait_for(0, 1'b1, 8);
        tick(30);
        chk(16'(sys_rst), 16'h0001);
        @(posedge clk_i);
        ext_low <= 1'b0; // Never pulled low again in this run
        hib     <= 1'b0;
        wait_for(0, 1'b0, 30);
        chk(16'(status.external), 16'h0001);
        clear_all();
        // Precise monitor trip on the digital regulator
        @(posedge clk_i);
        d_mv <= 13'h0384;
        wait_for(0, 1'b1, 8);
        @(posedge clk_i);
        d_mv <= 13'h0CE4;
        wait_for(0, 1'b0, 30);
        chk(16'(status.precise), 16'h0001);
        clear_all();
        // Low analog supply: interrupt, then reset
        @(posedge clk_i);
        a_mv <= 13'h05DC;
        wait_for(3, 1'b1, 8);
        chk(16'(sys_rst), 16'h0000);
        chk(16'(status.analog_low), 16'h0001);
        @(posedge clk_i);
        a_mv <= 13'h0CE4;
        clear_all();
        @(posedge clk_i);
        arst <= 1'b1;
        drst <= 1'b1;
        a_mv <= 13'h05DC;
        d_mv <= 13'h05DC;
        wait_for(0, 1'b1, 8);
        chk(16'(irq), 16'h0000);
        chk(16'(status.digital_low), 16'h0001);
        @(posedge clk_i);
        a_mv <= 13'h0CE4;
        d_mv <= 13'h0CE4;
        wait_for(0, 1'b0, 30);
        @(posedge clk_i);
        arst <= 1'b0;
        drst <= 1'b0;
        clear_all();
        // High analog supply at and above the fixed level
        @(posedge clk_i);
        a_mv <= 13'h1676;
        tick(8);
        chk(16'(irq[2]), 16'h0000);
        @(posedge clk_i);
        a_mv <= 13'h16A8;
        wait_for(4, 1'b1, 8);
        @(posedge clk_i);
        a_mv <= 13'h0CE4;
        clear_all();
        // Sleep with a buzz period shorter than the excursion
        @(posedge clk_i);
        slp  <= 1'b1; // Buzz period setting of 20, a buzz window every 21 cycles
        d_mv <= 13'h05DC;
        tick(2);
        chk(16'(mact), 16'h0000);
        chk(16'(pden), 16'h0000);
        wait_for(1, 1'b1, 60);
        chk(16'(pden), 16'h0001);
        wait_for(2, 1'b1, 12);
        chk(16'(irq[1]), 16'h0000);
        @(posedge clk_i);
        slp  <= 1'b0;
        d_mv <= 13'h0CE4;
        tick(2);
        chk(16'(irq[1]), 16'h0001);
        clear_all();
        // Watchdog kicked in time, then left to expire
        @(posedge clk_i);
        wds <= 1'b1;
        @(posedge clk_i);
        wds <= 1'b0;
        repeat (6) begin
            tick(30);
            @(posedge clk_i);
            wdk <= 1'b1;
            @(posedge clk_i);
            wdk <= 1'b0;
        end
        chk(16'(sys_rst), 16'h0000);
        wait_for(0, 1'b1, 60);
        chk(16'(status.watchdog), 16'h0001);
        wait_for(0, 1'b0, 30);
        chk(16'(wden), 16'h0001);
        // Power-on reset clears status and watchdog enable
        @(posedge clk_i);
        rst_i <= 1'b1;
        tick(3);
        chk(16'(wden), 16'h0000);
        chk(16'(status), 16'h0000);
        @(posedge clk_i);
        rst_i <= 1'b0;
        wait_for(0, 1'b0, 40);
        test_done();
    end
endmodule : tb_top
